// >>> dv/rca_bank_asserts.sv
// Purpose: Port-level checks of the channel alarm bank.
// Assumes: One clock domain; reset is asynchronous and active low.
// Notes:   Bound to every bank instance below the module.
`timescale 1ns/10ps
`default_nettype none
module rca_bank_asserts #(
  parameter ADDR_W = 20
) (
  // Clock, reset and bus
  input wire logic        ref_clk_i,
  input wire logic        nrst_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  // Receive status and alarm
  input wire logic [11:0] ais_sts_i,
  input wire logic [11:0] eso_sts_i,
  input wire logic        global_alarm_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // Both channels are held for one edge before the response is raised.
  a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o &&
    s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o
    |=> s_axi_rvalid_o) else $error("read data late");
  a_rdata_held: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped");
  a_bresp_held: assert property (s_axi_bvalid_o && !s_axi_bready_i
    |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");
  a_upper_zero: assert property (
    s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  a_ar_blocked: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read accepted while busy");
  a_aw_blocked: assert property (s_axi_bvalid_o |->
    !s_axi_awready_o && !s_axi_wready_o) else $error("write while busy");
  a_alarm_quiet: assert property (
    (ais_sts_i == 12'h0 && eso_sts_i == 12'h0)[*4] |-> !global_alarm_o)
    else $error("alarm without cause");
endmodule
bind rca_bank rca_bank_asserts #(.ADDR_W(ADDR_W)) u_chk (.ref_clk_i,
  .nrst_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
  .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
  .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o,
  .s_axi_rready_i, .ais_sts_i, .eso_sts_i, .global_alarm_o);
`default_nettype wire

// >>> dv/rca_bank_tb.sv
// Purpose: Register-level test of the channel alarm bank.
// Assumes: Word index times four is the byte address.
// Notes:   Waits for flags use the fixed three-edge input latency plus one.
`timescale 1ns/10ps
`default_nettype none
`include "rca_map.vh"
module rca_bank_tb;
  logic clk = 0, nrst = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic b1 = 0, oof = 0, awr, wr_o, bv, arr, rv, alarm, irq;
  logic [19:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd;
  logic [11:0] ais = 0, eso = 0;
  logic [1:0]  bresp, rresp;
  logic [3:0]  ws = 4'hF;
  int miscompares = 0, total_checks = 0, cyc = 0;
  rca_bank dut (.ref_clk_i(clk), .nrst_i(nrst), .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_o),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rd), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rr), .ais_sts_i(ais), .eso_sts_i(eso),
    .b1_err_i(b1), .oof_i(oof), .global_alarm_o(alarm), .irq_o(irq));
  initial forever #10 clk = ~clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [17:0] i, input logic [7:0] d,
                    input logic [1:0] er);
    logic a, w;
    a = 0; w = 0;
    awa <= {i, 2'b00}; wd <= {24'h0, d}; awv <= 1; wv <= 1;
    while (!(a && w)) begin
      @(posedge clk);
      if (!a && awr) begin a = 1; awv <= 0; end
      if (!w && wr_o) begin w = 1; wv <= 0; end
    end
    do @(posedge clk); while (!bv);
    // Ready follows the answer by one edge, so a stalled answer is seen.
    br <= 1;
    @(posedge clk);
    br <= 0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rdc(input logic [17:0] i, input logic [7:0] e,
                     input logic [1:0] er);
    ara <= {i, 2'b00}; arv <= 1;
    do @(posedge clk); while (!arr);
    arv <= 0;
    do @(posedge clk); while (!rv);
    rr <= 1;
    @(posedge clk);
    rr <= 0;
    chk(rd, {24'h0, e});
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  task automatic settle;
    repeat (4) @(posedge clk);
  endtask
  task automatic stop_test;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1;
    for (int k = `RCA_IDX_AIS_A; k <= `RCA_IDX_OOF_CNT; k++)
      rdc(k[17:0], 8'h00, `RCA_RESP_OKAY);
    $display("reset values done");
    ais <= 12'h802; eso <= 12'h802; settle();
    rdc(`RCA_IDX_AIS_A, 8'h08, `RCA_RESP_OKAY);
    rdc(`RCA_IDX_AIS_B, 8'h10, `RCA_RESP_OKAY);
    rdc(`RCA_IDX_ESO_A, 8'h08, `RCA_RESP_OKAY);
    rdc(`RCA_IDX_ESO_B, 8'h10, `RCA_RESP_OKAY);
    rdc(`RCA_IDX_SUMMARY, 8'h00, `RCA_RESP_OKAY);
    wr(`RCA_IDX_CHAN_EN, 8'h07, `RCA_RESP_OKAY);
    wr(`RCA_IDX_AIS_EN_A, 8'hFF, `RCA_RESP_OKAY);
    rdc(`RCA_IDX_AIS_EN_A, 8'h0F, `RCA_RESP_OKAY);
    settle();
    rdc(`RCA_IDX_SUMMARY, 8'h02, `RCA_RESP_OKAY);
    chk({31'h0, alarm}, 32'h1);
    wr(`RCA_IDX_AIS_EN_A, 8'h00, `RCA_RESP_OKAY);
    wr(`RCA_IDX_ESO_EN_B, 8'h10, `RCA_RESP_OKAY);
    rdc(`RCA_IDX_ESO_EN_B, 8'h10, `RCA_RESP_OKAY);
    settle();
    rdc(`RCA_IDX_SUMMARY, 8'h04, `RCA_RESP_OKAY);
    wr(`RCA_IDX_CHAN_EN, 8'h03, `RCA_RESP_OKAY);
    settle();
    chk({31'h0, alarm}, 32'h0);
    $display("alarm gating done");
    ais <= 12'h0; eso <= 12'h0;
    rdc(`RCA_IDX_IRQ_STAT, 8'h03, `RCA_RESP_OKAY);
    wr(`RCA_IDX_IRQ_MASK, 8'h04, `RCA_RESP_OKAY);
    b1 <= 1; repeat (5) @(posedge clk); b1 <= 0;
    rdc(`RCA_IDX_B1_CNT, 8'h05, `RCA_RESP_OKAY);
    rdc(`RCA_IDX_B1_CNT, 8'h00, `RCA_RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    b1 <= 1; repeat (128) @(posedge clk); b1 <= 0; @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    rdc(`RCA_IDX_B1_CNT, 8'hFF, `RCA_RESP_OKAY);
    rdc(`RCA_IDX_B1_CNT, 8'h00, `RCA_RESP_OKAY);
    rdc(`RCA_IDX_IRQ_STAT, 8'h04, `RCA_RESP_OKAY);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    $display("parity counter done");
    repeat (130) begin oof <= 1; @(posedge clk); oof <= 0; @(posedge clk); end
    rdc(`RCA_IDX_OOF_CNT, 8'hFF, `RCA_RESP_OKAY);
    rdc(`RCA_IDX_IRQ_STAT, 8'h08, `RCA_RESP_OKAY);
    oof <= 1; repeat (3) @(posedge clk); oof <= 0; @(posedge clk);
    rdc(`RCA_IDX_OOF_CNT, 8'h01, `RCA_RESP_OKAY);
    // A write with the low byte lane off must leave the enable untouched.
    ws <= 4'h0;
    wr(`RCA_IDX_AIS_EN_B, 8'hAA, `RCA_RESP_OKAY);
    ws <= 4'hF;
    rdc(`RCA_IDX_AIS_EN_B, 8'h00, `RCA_RESP_OKAY);
    rdc(18'h30028, 8'h00, `RCA_RESP_SLVERR);
    wr(18'h30028, 8'h55, `RCA_RESP_SLVERR);
    $display("frame loss counter done");
    stop_test();
  end
endmodule
`default_nettype wire

// >>> rtl/rca_bank.v
// Purpose: Receive channel alarm flags, enables and clear-on-read counters
//          behind an AXI4-Lite slave.
// Assumes: Framer and pointer mover inputs run on ref_clk_i.
// Notes:   Only the low byte of each word is used; upper bits read zero.
`timescale 1ns/10ps
`default_nettype none
`include "rca_map.vh"

module rca_bank #(
  parameter ADDR_W = 20
) (
  // Clock and reset
  input  wire              ref_clk_i,
  input  wire              nrst_i,
  // AXI4-Lite write address
  input  wire [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire              s_axi_awvalid_i,
  output wire              s_axi_awready_o,
  // AXI4-Lite write data
  input  wire [31:0]       s_axi_wdata_i,
  input  wire [3:0]        s_axi_wstrb_i,
  input  wire              s_axi_wvalid_i,
  output wire              s_axi_wready_o,
  // AXI4-Lite write response
  output reg  [1:0]        s_axi_bresp_o,
  output reg               s_axi_bvalid_o,
  input  wire              s_axi_bready_i,
  // AXI4-Lite read address
  input  wire [ADDR_W-1:0] s_axi_araddr_i,
  input  wire              s_axi_arvalid_i,
  output wire              s_axi_arready_o,
  // AXI4-Lite read data
  output reg  [31:0]       s_axi_rdata_o,
  output reg  [1:0]        s_axi_rresp_o,
  output reg               s_axi_rvalid_o,
  input  wire              s_axi_rready_i,
  // Receive path status, bit n is STS-1 number n+1
  input  wire [11:0]       ais_sts_i,
  input  wire [11:0]       eso_sts_i,
  input  wire              b1_err_i,
  input  wire              oof_i,
  // Alarm outputs
  output reg               global_alarm_o,
  output wire              irq_o
);

  // Register selects, one per mapped word.
  localparam SEL_NONE = 4'h0;
  localparam SEL_SUM  = 4'h1;
  localparam SEL_CEN  = 4'h2;
  localparam SEL_AISA = 4'h3;
  localparam SEL_AISB = 4'h4;
  localparam SEL_AEA  = 4'h5;
  localparam SEL_AEB  = 4'h6;
  localparam SEL_ESOA = 4'h7;
  localparam SEL_ESOB = 4'h8;
  localparam SEL_EEA  = 4'h9;
  localparam SEL_EEB  = 4'hA;
  localparam SEL_B1   = 4'hB;
  localparam SEL_OOF  = 4'hC;
  localparam SEL_IST  = 4'hD;
  localparam SEL_IMSK = 4'hE;

  // Byte address to register select; used on both read and write paths.
  function [3:0] decode;
    input [ADDR_W-1:0] addr;
    reg   [17:0]       idx;
    begin
      idx = addr[19:2];
      case (idx)
        `RCA_IDX_SUMMARY:  decode = SEL_SUM;
        `RCA_IDX_CHAN_EN:  decode = SEL_CEN;
        `RCA_IDX_AIS_A:    decode = SEL_AISA;
        `RCA_IDX_AIS_B:    decode = SEL_AISB;
        `RCA_IDX_AIS_EN_A: decode = SEL_AEA;
        `RCA_IDX_AIS_EN_B: decode = SEL_AEB;
        `RCA_IDX_ESO_A:    decode = SEL_ESOA;
        `RCA_IDX_ESO_B:    decode = SEL_ESOB;
        `RCA_IDX_ESO_EN_A: decode = SEL_EEA;
        `RCA_IDX_ESO_EN_B: decode = SEL_EEB;
        `RCA_IDX_B1_CNT:   decode = SEL_B1;
        `RCA_IDX_OOF_CNT:  decode = SEL_OOF;
        `RCA_IDX_IRQ_STAT: decode = SEL_IST;
        `RCA_IDX_IRQ_MASK: decode = SEL_IMSK;
        default:           decode = SEL_NONE;
      endcase
    end
  endfunction

  // Reorders per-STS bits into the two register groups:
  // group A holds STS 3, 6, 9, 12; group B holds 1, 4, 7, 10, 2, 5, 8, 11.
  function [11:0] sts_order;
    input [11:0] sts;
    begin
      sts_order = {sts[10], sts[7], sts[4], sts[1],
                   sts[9], sts[6], sts[3], sts[0],
                   sts[11], sts[8], sts[5], sts[2]};
    end
  endfunction

  // Flag and enable storage; flags are {group B, group A}.
  reg  [11:0] ais_flags;
  reg  [11:0] eso_flags;
  reg  [3:0]  ais_en_a;
  reg  [7:0]  ais_en_b;
  reg  [3:0]  eso_en_a;
  reg  [7:0]  eso_en_b;
  reg  [2:0]  chan_en;
  reg  [2:0]  summary;
  reg  [3:0]  irq_stat;
  reg  [3:0]  irq_mask;
  reg         oof_d;

  // Write channel holding registers.
  reg              aw_held;
  reg [ADDR_W-1:0] aw_addr;
  reg              w_held;
  reg [7:0]        w_byte;
  reg              w_lane;

  wire [3:0]  wr_sel;
  wire [3:0]  rd_sel;
  wire        wr_fire;
  wire        rd_fire;
  wire        wr_en;
  wire [7:0]  b1_value;
  wire [7:0]  oof_value;
  wire        b1_ovf_set;
  wire        oof_ovf_set;
  wire        oof_rise;
  wire [3:0]  irq_events;
  wire [11:0] ais_next;
  wire [11:0] eso_next;
  reg  [7:0]  rd_byte;

  assign s_axi_awready_o = ~aw_held & ~s_axi_bvalid_o;
  assign s_axi_wready_o  = ~w_held & ~s_axi_bvalid_o;
  assign s_axi_arready_o = ~s_axi_rvalid_o;
  assign wr_fire = aw_held & w_held & ~s_axi_bvalid_o;
  assign rd_fire = s_axi_arvalid_i & s_axi_arready_o;
  assign wr_sel  = decode(aw_addr);
  assign rd_sel  = decode(s_axi_araddr_i);
  assign wr_en   = wr_fire & w_lane;

  assign ais_next = sts_order(ais_sts_i);
  assign eso_next = sts_order(eso_sts_i);
  assign oof_rise = oof_i & ~oof_d;

  // Address and data are taken in either order and held until both exist.
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_held        <= 1'b0;
      aw_addr        <= {ADDR_W{1'b0}};
      w_held         <= 1'b0;
      w_byte         <= `RCA_RESET_BYTE;
      w_lane         <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= `RCA_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata_i[7:0];
        w_lane <= s_axi_wstrb_i[0];
      end
      if (wr_fire) begin
        aw_held        <= 1'b0;
        w_held         <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= (wr_sel == SEL_NONE) ? `RCA_RESP_SLVERR
                                               : `RCA_RESP_OKAY;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // Writable enables; bits beyond each field are simply not stored.
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ais_en_a <= 4'h0;
      ais_en_b <= 8'h00;
      eso_en_a <= 4'h0;
      eso_en_b <= 8'h00;
      chan_en  <= 3'h0;
      irq_mask <= 4'h0;
    end else if (wr_en) begin
      case (wr_sel)
        SEL_AEA:  ais_en_a <= w_byte[3:0];
        SEL_AEB:  ais_en_b <= w_byte;
        SEL_EEA:  eso_en_a <= w_byte[3:0];
        SEL_EEB:  eso_en_b <= w_byte;
        SEL_CEN:  chan_en  <= w_byte[2:0];
        SEL_IMSK: irq_mask <= w_byte[3:0];
        default:  ais_en_a <= ais_en_a;
      endcase
    end
  end

  // Live flags, summary and gated global alarm.
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ais_flags      <= 12'h000;
      eso_flags      <= 12'h000;
      summary        <= 3'h0;
      global_alarm_o <= 1'b0;
      oof_d          <= 1'b0;
    end else begin
      ais_flags <= ais_next;
      eso_flags <= eso_next;
      oof_d     <= oof_i;
      summary[0] <= 1'b0;
      summary[`RCA_SUM_AIS_BIT] <=
        |(ais_flags & {ais_en_b, ais_en_a});
      summary[`RCA_SUM_ESO_BIT] <=
        |(eso_flags & {eso_en_b, eso_en_a});
      global_alarm_o <= |(summary & chan_en);
    end
  end

  rca_evt_cnt u_b1_cnt (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .event_i   (b1_err_i),
    .clear_i   (rd_fire && (rd_sel == SEL_B1)),
    .value_o   (b1_value),
    .ovf_set_o (b1_ovf_set)
  );

  rca_evt_cnt u_oof_cnt (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .event_i   (oof_rise),
    .clear_i   (rd_fire && (rd_sel == SEL_OOF)),
    .value_o   (oof_value),
    .ovf_set_o (oof_ovf_set)
  );

  // Interrupt events: a flag group newly raised, or a counter overflowing.
  assign irq_events[`RCA_IRQ_AIS_BIT]     = |(ais_next & ~ais_flags);
  assign irq_events[`RCA_IRQ_ESO_BIT]     = |(eso_next & ~eso_flags);
  assign irq_events[`RCA_IRQ_B1_OVF_BIT]  = b1_ovf_set;
  assign irq_events[`RCA_IRQ_OOF_OVF_BIT] = oof_ovf_set;
  assign irq_o = |(irq_stat & irq_mask);

  // Reading the status clears it, but an event in that cycle survives.
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_stat <= 4'h0;
    end else if (rd_fire && (rd_sel == SEL_IST)) begin
      irq_stat <= irq_events;
    end else begin
      irq_stat <= irq_stat | irq_events;
    end
  end

  always @* begin
    case (rd_sel)
      SEL_SUM:  rd_byte = {5'h00, summary};
      SEL_CEN:  rd_byte = {5'h00, chan_en};
      SEL_AISA: rd_byte = {4'h0, ais_flags[3:0]};
      SEL_AISB: rd_byte = ais_flags[11:4];
      SEL_AEA:  rd_byte = {4'h0, ais_en_a};
      SEL_AEB:  rd_byte = ais_en_b;
      SEL_ESOA: rd_byte = {4'h0, eso_flags[3:0]};
      SEL_ESOB: rd_byte = eso_flags[11:4];
      SEL_EEA:  rd_byte = {4'h0, eso_en_a};
      SEL_EEB:  rd_byte = eso_en_b;
      SEL_B1:   rd_byte = b1_value;
      SEL_OOF:  rd_byte = oof_value;
      SEL_IST:  rd_byte = {4'h0, irq_stat};
      SEL_IMSK: rd_byte = {4'h0, irq_mask};
      default:  rd_byte = `RCA_RESET_BYTE;
    endcase
  end

  // Read data is captured at the address handshake, the same edge that
  // clears a counter, so the returned count is the one that was cleared.
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h00000000;
      s_axi_rresp_o  <= `RCA_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= {24'h000000, rd_byte};
      s_axi_rresp_o  <= (rd_sel == SEL_NONE) ? `RCA_RESP_SLVERR
                                             : `RCA_RESP_OKAY;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/rca_evt_cnt.v
// Purpose: Seven-bit clear-on-read event counter with sticky overflow.
// Assumes: Event and clear are single-cycle pulses on the bank clock.
// Notes:   The count saturates at its maximum once it overflows.
`timescale 1ns/10ps
`default_nettype none
`include "rca_map.vh"

module rca_evt_cnt (
  // Clock and reset
  input  wire       ref_clk_i,
  input  wire       nrst_i,
  // Event and read clear
  input  wire       event_i,
  input  wire       clear_i,
  // Register image
  output reg  [7:0] value_o,
  output wire       ovf_set_o
);

  wire at_max;

  assign at_max    = (value_o[6:0] == `RCA_CNT_MAX);
  assign ovf_set_o = event_i & at_max & ~value_o[`RCA_CNT_OVF_BIT];

  // An event in the clearing cycle is kept, so it starts the new count.
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      value_o <= `RCA_RESET_BYTE;
    end else if (clear_i) begin
      value_o <= {1'b0, 6'h00, event_i};
    end else if (event_i) begin
      if (at_max) begin
        value_o[`RCA_CNT_OVF_BIT] <= 1'b1;
      end else begin
        value_o[6:0] <= value_o[6:0] + 7'h01;
      end
    end
  end

endmodule
`default_nettype wire

// >>> rtl/rca_map.vh
// Purpose: Register map and field constants of the receive channel alarm
//          and counter bank.
// Assumes: Indices are word indices; byte address is four times the index.
// Notes:   Included by the bank top and its counter leaf.
//
// Summary of operation
// - AIS-P flag bit reads 1 while its STS-1 carries AIS; two groups.
// - Each AIS flag has a reset-zero enable; only enabled flags reach summary.
// - One read-only elastic store overflow flag per STS-1, same grouping.
// - Enabled elastic store overflow flags drive summary alarm bit 2.
// - Each elastic overflow flag has a reset-zero read-write enable bit.
// - Seven-bit B1 parity error counter in bits 0 to 6, clear on read.
// - Bit 7 of the B1 counter register reports counter overflow.
// - Seven-bit in-frame to out-of-frame transition counter, clear on read.
// - Bit 7 of the frame loss counter register reports counter overflow.
// - Summary bits gated by channel enable before reaching global alarm.
`ifndef RCA_MAP_VH
`define RCA_MAP_VH

`define RCA_IDX_SUMMARY       18'h30026
`define RCA_IDX_CHAN_EN       18'h30027
`define RCA_IDX_AIS_A         18'h3002A
`define RCA_IDX_AIS_B         18'h3002B
`define RCA_IDX_AIS_EN_A      18'h3002C
`define RCA_IDX_AIS_EN_B      18'h3002D
`define RCA_IDX_ESO_A         18'h3002E
`define RCA_IDX_ESO_B         18'h3002F
`define RCA_IDX_ESO_EN_A      18'h30030
`define RCA_IDX_ESO_EN_B      18'h30031
`define RCA_IDX_B1_CNT        18'h30032
`define RCA_IDX_OOF_CNT       18'h30033
`define RCA_IDX_IRQ_STAT      18'h30100
`define RCA_IDX_IRQ_MASK      18'h30101

`define RCA_SUM_AIS_BIT       1
`define RCA_SUM_ESO_BIT       2
`define RCA_CNT_MAX           7'h7F
`define RCA_CNT_OVF_BIT       7

`define RCA_IRQ_AIS_BIT       0
`define RCA_IRQ_ESO_BIT       1
`define RCA_IRQ_B1_OVF_BIT    2
`define RCA_IRQ_OOF_OVF_BIT   3

`define RCA_RESET_BYTE        8'h00
`define RCA_RESP_OKAY         2'h0
`define RCA_RESP_SLVERR       2'h2

`endif
